// ==== hdl/pscp_pkg.sv ====
package pscp_pkg;
	// ----------------------------------------------------------------
	// Wishbone register map (word aligned byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] COUNT_OFS  = 8'h08;
	// Control fields
	localparam int CTRL_AUTORST_BIT = 0;
	localparam int CTRL_USRCLK_BIT  = 1;
	localparam int CTRL_INITEN_BIT  = 2;
	localparam int CTRL_DUALIO_BIT  = 3;
	localparam int CTRL_VAR_LSB     = 4;
	localparam int CTRL_ERR_BIT     = 6;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ       = 200;
	localparam int STATUS_TO_US  = 40;
	localparam int STATUS_TO_CYC = STATUS_TO_US * CLK_MHZ;
	localparam int OSC_DIV_CYC   = 20;
	localparam logic [7:0] INIT_CYC_A  = 8'h88;
	localparam logic [7:0] INIT_CYC_B  = 8'h28;
	localparam logic [7:0] INIT_CYC_CD = 8'h0A;
	localparam int BYTE_FALLS    = 8;
	localparam logic [3:0] RDY_FALLS = 4'h7;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		PSCP_RESET = 5'b00001,
		PSCP_LOAD  = 5'b00010,
		PSCP_INIT  = 5'b00100,
		PSCP_USER  = 5'b01000,
		PSCP_ERROR = 5'b10000
	} pscp_state_t;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} pscp_wb_req_t;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pscp_wb_rsp_t;
endpackage : pscp_pkg

// ==== hdl/pscp_sync.sv ====
`timescale 1ns/100ps
// Two flop synchroniser, width parameterised
module pscp_sync
	import pscp_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async,
	output logic      [W-1:0] synced
);
	logic [W-1:0] meta;
	// First stage read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta   <= '0;
			synced <= '0;
		end else begin
			meta   <= async;
			synced <= meta;
		end
	end
endmodule : pscp_sync

// ==== hdl/pscp_top.sv ====
`timescale 1ns/100ps
// Overview of operation
// - Latch byte on rise, shift eight falls
// - Held in reset while request or status low
// - Release done line when all data received
// - Ready rises 6.5 clocks after byte latch
// - User clock init counts 136, 40 or 10
// - User clock ignored during data transfer
// - Init-done released at end of initialization
// - User mode drops weak pull-ups
// - Upper seven data pins tri-stated by default
// - Any clock period of two system clocks or longer tolerated, pauses allowed
// - Ready/busy shows serializing state
// - Error pulls status low, resets device
// - Auto-restart releases status within 40 us
// - Request low drives status, done low
// - Chain-enable out low when loading finished
// - Initialize only when shared done high
// - Shared status error stops every device
// - Grounded chain-enable loads identical streams
module pscp_top
	import pscp_pkg::*;
#(
	parameter int STATUS_TO = STATUS_TO_CYC
) (
	// System
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Wishbone slave
	input  wire pscp_wb_req_t wbReq,
	output pscp_wb_rsp_t      wbRsp,
	// Configuration pins
	input  wire logic         config_req_n,
	input  wire logic         dclk,
	input  wire logic [7:0]   dataIn,
	output logic [7:1]        dataOe,
	input  wire logic         user_startup_clock,
	input  wire logic         chain_enable_in_n,
	output logic              chain_enable_out_n,
	input  wire logic         statusIn,
	output logic              statusOe,
	input  wire logic         confDoneIn,
	output logic              confDoneOe,
	output logic              initDoneOe,
	output logic              ready_busy_n,
	output logic              weakPullupEn,
	output logic              userMode,
	// Loaded byte stream
	output logic [7:0]        cfgByte,
	output logic              cfgByteValid
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [13:0] pinSync;
	logic [7:0]  dataS;
	logic        reqS, dclkS, usrS, ceS, statS, doneS;
	pscp_sync #(.W(14)) uSync (
		.clk    (clk),
		.rst_n  (rst_n),
		.async  ({config_req_n, dclk, user_startup_clock, chain_enable_in_n, statusIn, confDoneIn, dataIn}),
		.synced (pinSync)
	);
	assign {reqS, dclkS, usrS, ceS, statS, doneS, dataS} = pinSync;

	// Edge detection on synchronised levels
	logic dclkQ, usrQ, doneQ, reqQ;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dclkQ <= 1'b0;
			usrQ  <= 1'b0;
			doneQ <= 1'b0;
			reqQ  <= 1'b0;
		end else begin
			dclkQ <= dclkS;
			usrQ  <= usrS;
			doneQ <= doneS;
			reqQ  <= reqS;
		end
	end
	wire dclkRise = dclkS & ~dclkQ;
	wire dclkFall = ~dclkS & dclkQ;
	wire usrRise  = usrS & ~usrQ;
	wire doneRise = doneS & ~doneQ;
	wire reqRise  = reqS & ~reqQ;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	logic [31:0] ctrl;
	logic [31:0] loadCount;
	logic [31:0] byteTarget;
	logic        errInject;
	wire wbHit = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
	wire wbWr  = wbHit & wbReq.we;

	// Software sets options and the expected stream length
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl       <= CTRL_RESET;
			byteTarget <= 32'h0000_0010;
			errInject  <= 1'b0;
		end else begin
			errInject <= 1'b0;
			if (wbWr && wbReq.adr == CTRL_OFS) begin
				for (int i = 0; i < 4; i++) begin
					if (wbReq.sel[i]) begin
						ctrl[i*8 +: 8] <= wbReq.dat[i*8 +: 8];
					end
				end
				errInject <= wbReq.dat[CTRL_ERR_BIT] & wbReq.sel[0];
			end
			if (wbWr && wbReq.adr == COUNT_OFS) begin
				byteTarget <= wbReq.dat;
			end
		end
	end

	// ----------------------------------------------------------------
	// Main sequencer
	// ----------------------------------------------------------------
	pscp_state_t state;
	logic [3:0]  fallCnt;
	logic [7:0]  shiftReg;
	logic [7:0]  initCnt;
	logic [4:0]  oscDiv;
	logic [31:0] toCnt;
	logic        initEnLatched;
	logic        busy;
	logic        useUsr;

	// Reset level: request low or shared status low holds off loading
	wire inReset = ~reqS | ~statS;
	wire oscTick = (oscDiv == 5'(OSC_DIV_CYC - 1));
	wire initTick = useUsr ? usrRise : oscTick;
	wire [7:0] initTarget = (ctrl[CTRL_VAR_LSB +: 2] == 2'b00) ? INIT_CYC_A :
	                        (ctrl[CTRL_VAR_LSB +: 2] == 2'b01) ? INIT_CYC_B : INIT_CYC_CD;
	wire selected = ~ceS;

	// Internal oscillator stand-in
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oscDiv <= '0;
		end else begin
			oscDiv <= oscTick ? 5'h00 : oscDiv + 5'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state         <= PSCP_RESET;
			fallCnt       <= '0;
			shiftReg      <= '0;
			initCnt       <= '0;
			toCnt         <= '0;
			loadCount     <= '0;
			initEnLatched <= 1'b0;
			useUsr        <= 1'b0;
			busy          <= 1'b0;
			cfgByte       <= '0;
			cfgByteValid  <= 1'b0;
		end else begin
			cfgByteValid <= 1'b0;
			unique case (state)
				PSCP_RESET: begin
					loadCount <= '0;
					busy      <= 1'b0;
					fallCnt   <= '0;
					if (!inReset) begin
						state <= PSCP_LOAD;
					end
				end
				PSCP_LOAD: begin
					// User clock is not looked at here
					if (errInject) begin
						state <= PSCP_ERROR;
						toCnt <= '0;
					end else if (inReset) begin
						state <= PSCP_RESET;
					end else if (selected && loadCount != byteTarget) begin
						if (dclkRise && !busy) begin
							shiftReg  <= dataS;
							busy      <= 1'b1;
							fallCnt   <= '0;
							cfgByte   <= dataS;
							if (loadCount == 32'h0) begin
								initEnLatched <= ctrl[CTRL_INITEN_BIT];
								useUsr        <= ctrl[CTRL_USRCLK_BIT];
							end
						end else if (dclkFall && busy) begin
							shiftReg <= {1'b0, shiftReg[7:1]};
							fallCnt  <= fallCnt + 4'h1;
							if (fallCnt == 4'(BYTE_FALLS - 1)) begin
								busy         <= 1'b0;
								cfgByteValid <= 1'b1;
								loadCount    <= loadCount + 32'h1;
							end
						end
					end else if (loadCount == byteTarget && doneRise) begin
						state   <= PSCP_INIT;
						initCnt <= '0;
					end
				end
				PSCP_INIT: begin
					if (inReset) begin
						state <= PSCP_RESET;
					end else if (initTick) begin
						if (initCnt == initTarget - 8'h01) begin
							state <= PSCP_USER;
						end
						initCnt <= initCnt + 8'h01;
					end
				end
				PSCP_USER: begin
					if (!reqS) begin
						state <= PSCP_RESET;
					end
				end
				PSCP_ERROR: begin
					toCnt <= toCnt + 32'h1;
					if (!reqS) begin
						state <= PSCP_RESET;
					end else if (ctrl[CTRL_AUTORST_BIT] && toCnt >= STATUS_TO - 1) begin
						state <= PSCP_RESET;
					end else if (!ctrl[CTRL_AUTORST_BIT] && reqRise) begin
						state <= PSCP_RESET;
					end
				end
				default: state <= PSCP_RESET;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			statusOe           <= 1'b1;
			confDoneOe         <= 1'b1;
			initDoneOe         <= 1'b0;
			chain_enable_out_n <= 1'b1;
			ready_busy_n       <= 1'b0;
			weakPullupEn       <= 1'b1;
			userMode           <= 1'b0;
			dataOe             <= '0;
		end else begin
			statusOe <= (state == PSCP_ERROR) || !reqS;
			// Done low until stream complete
			confDoneOe <= !reqS || !(state == PSCP_INIT || state == PSCP_USER ||
			              (state == PSCP_LOAD && loadCount == byteTarget));
			initDoneOe <= initEnLatched && (state == PSCP_LOAD || state == PSCP_INIT);
			chain_enable_out_n <= !(state != PSCP_RESET && state != PSCP_ERROR &&
			                       loadCount == byteTarget);
			// Ready rises after seventh fall, i.e. 6.5 clocks after latch
			ready_busy_n <= (state == PSCP_LOAD) && (!busy || fallCnt >= RDY_FALLS);
			// Request low leaves user mode in the same cycle that status and done are pulled
			weakPullupEn <= state != PSCP_USER || !reqS;
			userMode     <= state == PSCP_USER && reqS;
			dataOe       <= (state == PSCP_USER && reqS && ctrl[CTRL_DUALIO_BIT]) ? 7'h7F : 7'h00;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone answer: ack one cycle after request
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wbRsp <= '0;
		end else begin
			wbRsp.ack <= wbHit;
			wbRsp.dat <= 32'h0;
			if (wbHit && !wbReq.we) begin
				unique case (wbReq.adr)
					CTRL_OFS:   wbRsp.dat <= ctrl;
					STATUS_OFS: wbRsp.dat <= {20'h0, busy, 7'(state), reqS, statS, doneS, initEnLatched};
					COUNT_OFS:  wbRsp.dat <= loadCount;
					default:    wbRsp.dat <= 32'h0;
				endcase
			end
		end
	end
endmodule : pscp_top

// ==== test/pscp_host_model.sv ====
`timescale 1ns/100ps
// ----------------
// Host feeding configuration bytes
// ----------------
module pscp_host_model (
	// Device lines
	input  wire logic statusOe,
	input  wire logic confDoneOe,
	// Host drive
	output logic       config_req_n,
	output logic       dclk,
	output logic [7:0] dataIn,
	output logic       user_startup_clock,
	// Pulled-up open-drain wires
	output logic       statusIn,
	output logic       confDoneIn
);
	// Pull-up wins unless the device pulls low
	assign statusIn   = !statusOe;
	assign confDoneIn = !confDoneOe;
	// Start-up clock runs free, so it keeps toggling through restarts
	initial begin
		user_startup_clock = 1'b0;
		forever #15 user_startup_clock = !user_startup_clock;
	end
	initial begin
		config_req_n = 1'b1;
		dclk = 1'b0;
		dataIn = 8'h00;
	end
	// Byte held for eight clocks; clock idles low between bytes
	task automatic sendByte(input logic [7:0] b);
		dataIn = b;
		repeat (8) begin
			#24 dclk = 1'b1;
			#24 dclk = 1'b0;
		end
		dataIn = ~b;
	endtask : sendByte
	// Low pulse long enough for every variant
	task automatic pulseReq();
		config_req_n = 1'b0;
		#21000 config_req_n = 1'b1;
	endtask : pulseReq
endmodule : pscp_host_model

// ==== test/pscp_assertions.sv ====
`timescale 1ns/100ps
// ----------------
// Port checker
// ----------------
module pscp_assertions
	import pscp_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst_n,
	input wire pscp_wb_req_t wbReq,
	input wire pscp_wb_rsp_t wbRsp,
	input wire logic         config_req_n,
	input wire logic         cfgByteValid,
	input wire logic         ready_busy_n,
	input wire logic         userMode,
	input wire logic         weakPullupEn,
	input wire logic         initDoneOe,
	input wire logic         statusOe,
	input wire logic         confDoneOe,
	input wire logic [7:1]   dataOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Four samples cover the two-flop synchroniser delay
	a_req_holds_reset: assert property (!config_req_n [*4] |-> statusOe && confDoneOe)
		else $error("status or done not pulled while request low");
	a_req_leaves_user: assert property (!config_req_n [*4] |-> !userMode)
		else $error("user mode kept while request low");
	a_ack_one_cycle: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
		else $error("bus answer late");
	a_ack_drops: assert property (wbRsp.ack |=> !wbRsp.ack)
		else $error("bus answer held");
	a_byte_ready: assert property (cfgByteValid |-> ready_busy_n)
		else $error("busy after byte serialized");
	a_byte_pulse: assert property (cfgByteValid |=> !cfgByteValid)
		else $error("byte strobe held");
	a_user_pullup: assert property (userMode |-> !weakPullupEn && !initDoneOe)
		else $error("pull-ups or init-done kept in user mode");
	a_user_lines: assert property (userMode |-> !statusOe && !confDoneOe)
		else $error("status or done pulled in user mode");
	a_pins_tristate: assert property (!userMode |-> dataOe == 7'h00)
		else $error("upper data pins driven before user mode");
	c_byte: cover property (cfgByteValid);
	c_user: cover property ($rose(userMode));
	c_error: cover property ($rose(statusOe) && config_req_n);
endmodule : pscp_assertions

bind pscp_top pscp_assertions chk_u (
	.clk(clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp), .config_req_n(config_req_n),
	.cfgByteValid(cfgByteValid), .ready_busy_n(ready_busy_n), .userMode(userMode),
	.weakPullupEn(weakPullupEn), .initDoneOe(initDoneOe), .statusOe(statusOe),
	.confDoneOe(confDoneOe), .dataOe(dataOe)
);

// ==== test/tb_pscp_top.sv ====
`timescale 1ns/100ps
// ----------------
// Bench
// ----------------
module tb_pscp_top
	import pscp_pkg::*;
;
	logic         clk, rst_n, cfgByteValid, userMode, weakPullupEn, statusIn, statusOe;
	logic         config_req_n, dclk, user_startup_clock, confDoneIn, confDoneOe;
	logic         initDoneOe, ready_busy_n, chain_enable_out_n, hit;
	logic [7:0]   dataIn, cfgByte;
	logic [7:1]   dataOe;
	logic [31:0]  seed, rd;
	pscp_wb_req_t wbReq;
	pscp_wb_rsp_t wbRsp;
	int           mismatches, n_compared, usrCnt;
	logic [7:0]   expQ[$];
	// Clock and start-up clock counter
	initial begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end
	always @(posedge user_startup_clock) usrCnt <= usrCnt + 1;
	// Every delivered byte must match the next one sent
	always @(posedge clk) if (cfgByteValid === 1'b1) chk(32'(cfgByte), 32'(expQ.pop_front()));
	pscp_host_model host_u (.statusOe(statusOe), .confDoneOe(confDoneOe), .config_req_n(config_req_n),
		.dclk(dclk), .dataIn(dataIn), .user_startup_clock(user_startup_clock), .statusIn(statusIn),
		.confDoneIn(confDoneIn));
	// Short status timeout keeps the restart test brief
	pscp_top #(.STATUS_TO(50)) dut_u (.clk(clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
		.config_req_n(config_req_n), .dclk(dclk), .dataIn(dataIn), .dataOe(dataOe),
		.user_startup_clock(user_startup_clock), .chain_enable_in_n(1'b0),
		.chain_enable_out_n(chain_enable_out_n), .statusIn(statusIn), .statusOe(statusOe),
		.confDoneIn(confDoneIn), .confDoneOe(confDoneOe), .initDoneOe(initDoneOe),
		.ready_busy_n(ready_busy_n), .weakPullupEn(weakPullupEn), .userMode(userMode),
		.cfgByte(cfgByte), .cfgByteValid(cfgByteValid));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// Classic single cycle; waits for ack under a bound
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		@(posedge clk);
		wbReq <= '{1'b1, 1'b1, we, 4'hF, adr, d};
		hit = 1'b0;
		for (int i = 0; i < 20 && !hit; i++) begin
			@(posedge clk);
			hit = wbRsp.ack === 1'b1;
		end
		rd = wbRsp.dat;
		wbReq <= '0;
		if (!hit) mismatches++;
		if (!hit) final_report();
	endtask : wb
	// Wait on user mode (0), status (1) or done (2)
	task automatic waitSig(input int s, input logic v, input int lim);
		hit = 1'b0;
		for (int i = 0; i < lim && !hit; i++) begin
			@(posedge clk);
			hit = ((s == 0) ? userMode : (s == 1) ? statusIn : confDoneIn) === v;
		end
		if (!hit) mismatches++;
		if (!hit) final_report();
	endtask : waitSig
	// Full load and start-up with the given options
	task automatic cfg(input logic [31:0] ctrl, input int nb, input bit pulse);
		int n;
		if (pulse) host_u.pulseReq();
		waitSig(1, 1'b1, 100);
		wb(1'b1, COUNT_OFS, nb);
		wb(1'b1, CTRL_OFS, ctrl);
		for (int i = 0; i < nb; i++) begin
			seed = xs(seed);
			expQ.push_back(seed[7:0]);
			host_u.sendByte(seed[7:0]);
			if (i == 0) chk(32'(initDoneOe), 32'(ctrl[2]));
		end
		waitSig(2, 1'b1, 300);
		chk(32'(chain_enable_out_n), 0);
		usrCnt = 0;
		waitSig(0, 1'b1, 4000);
		n = (ctrl[5:4] == 2'h0) ? 136 : (ctrl[5:4] == 2'h1) ? 40 : 10;
		if (ctrl[1]) chk(32'(usrCnt >= n - 1 && usrCnt <= n + 2), 1);
		chk(32'(weakPullupEn), 0);
		chk(32'(dataOe), 32'({7{ctrl[3]}}));
		$display("load done ctrl %h", ctrl);
	endtask : cfg
	// Main sequence
	initial begin
		rst_n = 1'b0;
		wbReq = '0;
		seed = 32'hA798;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, CTRL_OFS, 0);
		chk(rd, CTRL_RESET);
		wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
		wb(1'b0, 8'hFC, 0);
		chk(rd, 0);
		cfg(32'h0000_0005, 4, 1);
		for (int v = 0; v < 4; v++) cfg(32'h3 | (v << 4) | ((v == 3) << 3), 3, 1);
		host_u.pulseReq();
		cfg(32'h0000_0001, 1, 0);
		host_u.pulseReq();
		waitSig(1, 1'b1, 100);
		wb(1'b1, CTRL_OFS, 32'h0000_0041);
		waitSig(1, 1'b0, 20);
		chk(32'(userMode), 0);
		waitSig(1, 1'b1, 80);
		cfg(32'h0000_0001, 2, 0);
		host_u.pulseReq();
		waitSig(1, 1'b1, 100);
		wb(1'b1, CTRL_OFS, 32'h0000_0040);
		repeat (100) @(posedge clk);
		chk(32'(statusIn), 0);
		cfg(32'h0000_0001, 2, 1);
		final_report();
	end
endmodule : tb_pscp_top
